/* File: rtl/synth_regs_pkg.sv */
// Package: register map, field positions and reset values of the synthesizer control bank
package synth_regs_pkg;
   // ==========================================
   // Word format
   localparam int WORD_W = 24;
   localparam int SEL_W = 3;
   localparam logic [4:0] BIT_CNT_LAST = 5'h17;
   // ==========================================
   // Register selects
   localparam logic [2:0] SEL_INTEGER = 3'h0;
   localparam logic [2:0] SEL_MODULUS = 3'h1;
   localparam logic [2:0] SEL_FRACTION = 3'h2;
   localparam logic [2:0] SEL_DITHER = 3'h3;
   localparam logic [2:0] SEL_PUMP = 3'h4;
   localparam logic [2:0] SEL_LO_PATH = 3'h5;
   localparam logic [2:0] SEL_OSC = 3'h6;
   // ==========================================
   // Field positions
   localparam int INT_LSB = 3;
   localparam int DM_POS = 10;
   localparam int FRAC_LSB = 3;
   localparam int CPMUL_LSB = 10;
   localparam int OFS_LSB = 12;
   localparam int OFS_SIGN_POS = 17;
   localparam int RSET_POS = 18;
   localparam int REFSCALE_LSB = 19;
   localparam int MONSEL_LSB = 21;
   localparam int LO_DIR_POS = 3;
   localparam int LO_DIV_POS = 4;
   localparam int DEMOD_BIAS_POS = 7;
   localparam int BAND_LSB = 3;
   localparam int BSRC_POS = 9;
   localparam int AMP_LSB = 10;
   localparam int VCO_EN_POS = 17;
   localparam int OSC_REG_POS = 18;
   localparam int REG33_POS = 19;
   localparam int PUMP_EN_POS = 20;
   // ==========================================
   // Reset values
   localparam logic [6:0] INT_RST = 7'h38;
   localparam logic [10:0] MOD_RST = 11'h600;
   localparam logic [10:0] FRAC_RST = 11'h300;
   localparam logic [16:0] DITHER_RST = 17'h00001;
   localparam logic [5:0] AMP_RST = 6'h18;
   localparam logic [2:0] MONSEL_LOCK = 3'h0;
   // Monitor output choices
   localparam logic [2:0] MON_LOCK = 3'h0;
   localparam logic [2:0] MON_CAL_BUSY = 3'h1;
   localparam logic [2:0] MON_HIGH = 3'h2;
   localparam logic [2:0] MON_LOW = 3'h3;
   // Reference scale codes: 0=x2,1=x1,2=x0.5,3=x0.25
   localparam logic [1:0] REF_X1 = 2'h1;

   // Decoded control bundle for the analog loop
   typedef struct packed {
      logic frac_mode;
      logic [6:0] int_ratio;
      logic [10:0] modulus;
      logic [10:0] numerator;
      logic [16:0] dither;
   } divide_cfg_t;

   typedef struct packed {
      logic ext_rset;
      logic [2:0] pump_mult;
      logic [4:0] phase_ofs;
      logic ofs_negative;
      logic [1:0] ref_scale;
      logic [2:0] mon_sel;
   } pump_cfg_t;

   typedef struct packed {
      logic lo_port_out;
      logic lo_div2;
      logic demod_bias_en;
      logic band_from_spi;
      logic [5:0] band_sel;
      logic [5:0] amplitude;
      logic vco_en;
      logic osc_reg_en;
      logic reg33_en;
      logic pump_en;
   } osc_cfg_t;
endpackage

/* File: rtl/synth_pll_control_registers.sv */
// Serial-programmed control register bank for the fractional-N synthesizer
`timescale 1ns/1ps

// Functional notes
// RL1: Select bits 000 load integer register
// RL2: Host keeps integer ratio in legal range
// RL3: Integer mode ignores numerator and modulus
// RL4: Select 001 loads 11-bit modulus
// RL5: Select 010 loads 11-bit numerator
// RL6: Host keeps numerator below modulus
// RL7: Select 011 loads dither restart value
// RL8: Select 100 loads pump/phase/ref/monitor
// RL9: Bit 18 picks internal or external resistor
// RL10: Pump multiplier is one plus bits 11:10
// RL11: Bits 16:12 set phase offset
// RL12: Bit 17 sets phase offset sign
// RL13: Reference scaled by 2,1,0.5,0.25
// RL14: Monitor pin selectable, defaults to lock
// RL15: LO path register sets direction, divider, bias
// RL16: Select 110 loads oscillator control register
// RL17: Band source picks calibration or programmed band
// RL18: Amplitude 0 to 31, resets to 24
// RL19: Separate oscillator and regulator enables
// RL20: Three-wire serial port writes one word
// RL21: Frequency register writes start calibration
// RL22: Bits 20..17 enable pump, regulators, oscillator
// RL23: Only complete 24-bit words update registers
module synth_pll_control_registers (
   // System clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Three-wire serial port (link domain)
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_le,
   // Status from analog loop (asynchronous)
   input wire logic lock_detect,
   input wire logic cal_done,
   // Decoded controls
   output synth_regs_pkg::divide_cfg_t divide_cfg,
   output synth_regs_pkg::pump_cfg_t pump_cfg,
   output synth_regs_pkg::osc_cfg_t osc_cfg,
   output logic [5:0] band_active,
   output logic cal_start,
   output logic cal_busy,
   output logic monitor_output_pin
);

   // ==========================================
   // Link domain: shift register
   logic [23:0] shift_ff; // Incoming bits, MSB first
   logic [4:0] cnt_ff; // Bits received this frame
   logic [23:0] word_ff; // Completed word held for the system domain
   logic word_tgl_ff; // Toggles once per completed word
   logic full_w;
   logic [4:0] nxt_cnt;

   // Word is complete once 24 bits are in
   assign full_w = (cnt_ff > synth_regs_pkg::BIT_CNT_LAST);
   assign nxt_cnt = full_w ? cnt_ff : cnt_ff + 5'h01;

   // Shift while frame open; bit count cleared by the frame signal itself
   // Long frames keep their last 24 bits; short frames never latch
   always_ff @(posedge ser_clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_ff <= 24'h000000;
         cnt_ff <= 5'h00;
      end else if (ser_le) begin
         // Latch edge closes frame; next frame starts fresh
         cnt_ff <= 5'h00;
      end else begin
         shift_ff <= {shift_ff[22:0], ser_data}; // see RL20
         cnt_ff <= nxt_cnt;
      end
   end

   // Latch the word on the latch-enable edge, only when 24 bits are in
   always_ff @(posedge ser_clk or negedge rst_b) begin
      if (!rst_b) begin
         word_ff <= 24'h000000;
         word_tgl_ff <= 1'b0;
      end else if (ser_le && (cnt_ff == 5'(synth_regs_pkg::WORD_W))) begin
         word_ff <= shift_ff; // see RL23
         word_tgl_ff <= ~word_tgl_ff;
      end
   end

   // ==========================================
   // Crossing into the system domain
   logic [2:0] tgl_sync_ff; // Two-stage synchroniser plus edge history
   logic [1:0] lock_sync_ff;
   logic [1:0] cal_sync_ff;
   logic word_evt_w;

   // Toggle synchroniser; word_ff is stable long before the toggle lands
   // Only the second and later stages of each chain are read; the first may be metastable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_sync_ff <= 3'h0;
         lock_sync_ff <= 2'h0;
         cal_sync_ff <= 2'h0;
      end else begin
         tgl_sync_ff <= {tgl_sync_ff[1:0], word_tgl_ff};
         lock_sync_ff <= {lock_sync_ff[0], lock_detect};
         cal_sync_ff <= {cal_sync_ff[0], cal_done};
      end
   end

   assign word_evt_w = tgl_sync_ff[2] ^ tgl_sync_ff[1];

   // ==========================================
   // Register selection
   logic [2:0] sel_w;
   logic wr_int_w;
   logic wr_mod_w;
   logic wr_frac_w;
   logic wr_dith_w;
   logic wr_pump_w;
   logic wr_lo_w;
   logic wr_osc_w;

   assign sel_w = word_ff[2:0];
   assign wr_int_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_INTEGER); // see RL1
   assign wr_mod_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_MODULUS); // see RL4
   assign wr_frac_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_FRACTION); // see RL5
   assign wr_dith_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_DITHER); // see RL7
   assign wr_pump_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_PUMP); // see RL8
   assign wr_lo_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_LO_PATH); // see RL15
   assign wr_osc_w = word_evt_w && (sel_w == synth_regs_pkg::SEL_OSC); // see RL16

   // ==========================================
   // Register storage
   logic dm_ff; // 0 fractional, 1 integer
   logic [6:0] int_ff;
   logic [10:0] mod_ff;
   logic [10:0] frac_ff;
   logic [16:0] dith_ff;
   logic ext_rset_ff;
   logic [1:0] cpmul_ff;
   logic [4:0] ofs_ff;
   logic ofs_neg_ff;
   logic [1:0] ref_ff;
   logic [2:0] mon_ff;
   logic lo_out_ff;
   logic lo_div2_ff;
   logic bias_ff;
   logic [5:0] band_ff;
   logic bsrc_ff;
   logic [5:0] amp_ff;
   logic vco_en_ff;
   logic osc_reg_ff;
   logic reg33_ff;
   logic pump_en_ff;

   // Frequency registers: integer, modulus, numerator, dither
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dm_ff <= 1'b0;
         int_ff <= synth_regs_pkg::INT_RST;
         mod_ff <= synth_regs_pkg::MOD_RST;
         frac_ff <= synth_regs_pkg::FRAC_RST;
         dith_ff <= synth_regs_pkg::DITHER_RST;
      end else begin
         if (wr_int_w) begin
            int_ff <= word_ff[synth_regs_pkg::INT_LSB +: 7];
            dm_ff <= word_ff[synth_regs_pkg::DM_POS];
         end
         if (wr_mod_w) begin
            mod_ff <= word_ff[synth_regs_pkg::FRAC_LSB +: 11]; // see RL4
         end
         if (wr_frac_w) begin
            frac_ff <= word_ff[synth_regs_pkg::FRAC_LSB +: 11]; // see RL5
         end
         if (wr_dith_w) begin
            dith_ff <= word_ff[synth_regs_pkg::FRAC_LSB +: 17];
         end
      end
   end

   // Pump, phase offset, reference scaling and monitor selection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_rset_ff <= 1'b0;
         cpmul_ff <= 2'h0;
         ofs_ff <= 5'h00;
         ofs_neg_ff <= 1'b0;
         ref_ff <= synth_regs_pkg::REF_X1;
         mon_ff <= synth_regs_pkg::MONSEL_LOCK; // see RL14
      end else if (wr_pump_w) begin
         ext_rset_ff <= word_ff[synth_regs_pkg::RSET_POS]; // see RL9
         cpmul_ff <= word_ff[synth_regs_pkg::CPMUL_LSB +: 2];
         ofs_ff <= word_ff[synth_regs_pkg::OFS_LSB +: 5]; // see RL11
         ofs_neg_ff <= word_ff[synth_regs_pkg::OFS_SIGN_POS]; // see RL12
         ref_ff <= word_ff[synth_regs_pkg::REFSCALE_LSB +: 2]; // see RL13
         mon_ff <= word_ff[synth_regs_pkg::MONSEL_LSB +: 3];
      end
   end

   // LO path and oscillator controls
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lo_out_ff <= 1'b0;
         lo_div2_ff <= 1'b0;
         bias_ff <= 1'b1;
         band_ff <= 6'h00;
         bsrc_ff <= 1'b0;
         amp_ff <= synth_regs_pkg::AMP_RST; // see RL18
         vco_en_ff <= 1'b1;
         osc_reg_ff <= 1'b1;
         reg33_ff <= 1'b1;
         pump_en_ff <= 1'b1;
      end else begin
         if (wr_lo_w) begin
            lo_out_ff <= word_ff[synth_regs_pkg::LO_DIR_POS]; // see RL15
            lo_div2_ff <= word_ff[synth_regs_pkg::LO_DIV_POS];
            bias_ff <= word_ff[synth_regs_pkg::DEMOD_BIAS_POS];
         end
         if (wr_osc_w) begin
            band_ff <= word_ff[synth_regs_pkg::BAND_LSB +: 6];
            bsrc_ff <= word_ff[synth_regs_pkg::BSRC_POS];
            // Field is six bits wide but only 0..31 is meaningful
            amp_ff <= word_ff[synth_regs_pkg::AMP_LSB +: 6]; // see RL18
            vco_en_ff <= word_ff[synth_regs_pkg::VCO_EN_POS]; // see RL22
            osc_reg_ff <= word_ff[synth_regs_pkg::OSC_REG_POS]; // see RL19
            reg33_ff <= word_ff[synth_regs_pkg::REG33_POS]; // see RL22
            pump_en_ff <= word_ff[synth_regs_pkg::PUMP_EN_POS]; // see RL22
         end
      end
   end

   // ==========================================
   // Calibration start and busy
   logic cal_start_ff;
   logic freq_wr_ff; // Frequency write, one cycle late
   logic cal_busy_ff;
   logic [5:0] cal_band_ff; // Band found by last calibration
   logic freq_wr_w;

   // Any frequency write restarts calibration, even with unchanged data
   assign freq_wr_w = wr_int_w | wr_mod_w | wr_frac_w; // see RL21

   // Busy set wins over a finishing calibration in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cal_start_ff <= 1'b0;
         freq_wr_ff <= 1'b0;
         cal_busy_ff <= 1'b0;
         cal_band_ff <= 6'h00;
      end else begin
         // Pulse lands with the output flops, so the loop calibrates the new ratio
         freq_wr_ff <= freq_wr_w;
         cal_start_ff <= freq_wr_ff; // see RL21
         if (freq_wr_w) begin
            cal_busy_ff <= 1'b1;
         end else if (cal_sync_ff[1]) begin
            cal_busy_ff <= 1'b0;
            cal_band_ff <= band_ff;
         end
      end
   end

   // ==========================================
   // Output decode
   synth_regs_pkg::divide_cfg_t nxt_divide_cfg; // Divider controls for the output flops
   synth_regs_pkg::pump_cfg_t nxt_pump_cfg; // Pump, offset, reference and monitor controls
   synth_regs_pkg::osc_cfg_t nxt_osc_cfg; // LO path and oscillator controls
   logic [5:0] nxt_band_active; // Band handed to the oscillator
   logic nxt_mon; // Monitor level before its flop

   // Integer mode zeroes the fractional part seen by the divider
   assign nxt_divide_cfg.frac_mode = ~dm_ff; // see RL3
   assign nxt_divide_cfg.int_ratio = int_ff;
   assign nxt_divide_cfg.modulus = dm_ff ? 11'h001 : mod_ff; // see RL3
   assign nxt_divide_cfg.numerator = dm_ff ? 11'h000 : frac_ff; // see RL3
   assign nxt_divide_cfg.dither = dith_ff;

   // Multiplier leaves as one plus the stored field
   assign nxt_pump_cfg.ext_rset = ext_rset_ff; // see RL9
   assign nxt_pump_cfg.pump_mult = {1'b0, cpmul_ff} + 3'h1; // see RL10
   assign nxt_pump_cfg.phase_ofs = ofs_ff;
   assign nxt_pump_cfg.ofs_negative = ofs_neg_ff;
   assign nxt_pump_cfg.ref_scale = ref_ff;
   assign nxt_pump_cfg.mon_sel = mon_ff;

   // LO path and oscillator fields pass straight through
   assign nxt_osc_cfg.lo_port_out = lo_out_ff;
   assign nxt_osc_cfg.lo_div2 = lo_div2_ff;
   assign nxt_osc_cfg.demod_bias_en = bias_ff;
   assign nxt_osc_cfg.band_from_spi = bsrc_ff;
   assign nxt_osc_cfg.band_sel = band_ff;
   assign nxt_osc_cfg.amplitude = amp_ff;
   assign nxt_osc_cfg.vco_en = vco_en_ff;
   assign nxt_osc_cfg.osc_reg_en = osc_reg_ff;
   assign nxt_osc_cfg.reg33_en = reg33_ff;
   assign nxt_osc_cfg.pump_en = pump_en_ff;

   // Band from programmed field or from the calibration result
   assign nxt_band_active = bsrc_ff ? band_ff : cal_band_ff; // see RL17

   // Monitor mux; unused codes drive low
   assign nxt_mon = (mon_ff == synth_regs_pkg::MON_LOCK) ? lock_sync_ff[1] :
      (mon_ff == synth_regs_pkg::MON_CAL_BUSY) ? cal_busy_ff :
      (mon_ff == synth_regs_pkg::MON_HIGH); // see RL14

   // ==========================================
   // Output registers
   synth_regs_pkg::divide_cfg_t divide_cfg_ff; // Divider controls at the port
   synth_regs_pkg::pump_cfg_t pump_cfg_ff; // Pump controls at the port
   synth_regs_pkg::osc_cfg_t osc_cfg_ff; // Oscillator controls at the port
   logic [5:0] band_active_ff; // Band at the port
   logic mon_out_ff; // Monitor pin flop

   // Divider outputs; reset equals the stored defaults, so no step after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         divide_cfg_ff.frac_mode <= 1'b1;
         divide_cfg_ff.int_ratio <= synth_regs_pkg::INT_RST;
         divide_cfg_ff.modulus <= synth_regs_pkg::MOD_RST;
         divide_cfg_ff.numerator <= synth_regs_pkg::FRAC_RST;
         divide_cfg_ff.dither <= synth_regs_pkg::DITHER_RST;
      end else begin
         divide_cfg_ff <= nxt_divide_cfg;
      end
   end

   // Pump, offset, reference and monitor selection outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pump_cfg_ff.ext_rset <= 1'b0;
         pump_cfg_ff.pump_mult <= 3'h1;
         pump_cfg_ff.phase_ofs <= 5'h00;
         pump_cfg_ff.ofs_negative <= 1'b0;
         pump_cfg_ff.ref_scale <= synth_regs_pkg::REF_X1;
         pump_cfg_ff.mon_sel <= synth_regs_pkg::MONSEL_LOCK;
      end else begin
         pump_cfg_ff <= nxt_pump_cfg;
      end
   end

   // LO path and oscillator outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_cfg_ff.lo_port_out <= 1'b0;
         osc_cfg_ff.lo_div2 <= 1'b0;
         osc_cfg_ff.demod_bias_en <= 1'b1;
         osc_cfg_ff.band_from_spi <= 1'b0;
         osc_cfg_ff.band_sel <= 6'h00;
         osc_cfg_ff.amplitude <= synth_regs_pkg::AMP_RST;
         osc_cfg_ff.vco_en <= 1'b1;
         osc_cfg_ff.osc_reg_en <= 1'b1;
         osc_cfg_ff.reg33_en <= 1'b1;
         osc_cfg_ff.pump_en <= 1'b1;
      end else begin
         osc_cfg_ff <= nxt_osc_cfg;
      end
   end

   // Active band and monitor pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         band_active_ff <= 6'h00;
         mon_out_ff <= 1'b0;
      end else begin
         band_active_ff <= nxt_band_active;
         mon_out_ff <= nxt_mon;
      end
   end

   // Every control leaves from a flop, so the analog side sees no decode glitches
   assign divide_cfg = divide_cfg_ff;
   assign pump_cfg = pump_cfg_ff;
   assign osc_cfg = osc_cfg_ff;
   assign band_active = band_active_ff;
   assign cal_start = cal_start_ff;
   assign cal_busy = cal_busy_ff;
   assign monitor_output_pin = mon_out_ff;

endmodule // synth_pll_control_registers

/* File: verification/synth_regs_monitor.sv */
// Checker for the synthesizer control register bank
`timescale 1ns/1ps
module synth_regs_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial port and loop status
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_le,
   input wire logic lock_detect,
   input wire logic cal_done,
   // Decoded controls
   input wire synth_regs_pkg::divide_cfg_t divide_cfg,
   input wire synth_regs_pkg::pump_cfg_t pump_cfg,
   input wire synth_regs_pkg::osc_cfg_t osc_cfg,
   input wire logic [5:0] band_active,
   input wire logic cal_start,
   input wire logic cal_busy,
   input wire logic monitor_output_pin
);
   // ==========================================
   // Clocking and helper nets
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Frequency part only: a dither write must not calibrate
   wire logic [29:0] freq_part = {divide_cfg.frac_mode, divide_cfg.int_ratio,
      divide_cfg.modulus, divide_cfg.numerator};
   // ==========================================
   // Properties
   property p_cal_pulse; cal_start |=> !cal_start; endproperty
   a_cal_pulse: assert property (p_cal_pulse) else $error("cal pulse too long");
   property p_freq_cal; !$stable(freq_part) |-> cal_start; endproperty
   a_freq_cal: assert property (p_freq_cal) else $error("no cal after write");
   property p_cal_busy; cal_start && !cal_done |-> ##[0:2] cal_busy; endproperty
   a_cal_busy: assert property (p_cal_busy) else $error("busy not set");
   property p_int_mode; !divide_cfg.frac_mode |-> divide_cfg.modulus == 11'h001
      && divide_cfg.numerator == 11'h000; endproperty
   a_int_mode: assert property (p_int_mode) else $error("integer mode leak");
   property p_pump_mult; pump_cfg.pump_mult inside {[3'h1:3'h4]}; endproperty
   a_pump_mult: assert property (p_pump_mult) else $error("bad pump multiplier");
   property p_band_src; (osc_cfg.band_from_spi && $stable(osc_cfg.band_sel)) [*3]
      |-> band_active == osc_cfg.band_sel; endproperty
   a_band_src: assert property (p_band_src) else $error("band not from field");
   property p_mon_fixed; (pump_cfg.mon_sel inside {3'h2, 3'h3}) [*2]
      |-> monitor_output_pin == (pump_cfg.mon_sel == 3'h2); endproperty
   a_mon_fixed: assert property (p_mon_fixed) else $error("monitor level wrong");
   property p_mon_busy; (pump_cfg.mon_sel == 3'h1 && $stable(cal_busy)) [*2]
      |-> monitor_output_pin == cal_busy; endproperty
   a_mon_busy: assert property (p_mon_busy) else $error("monitor not busy");
   property p_reset_vals; $rose(rst_b) |-> osc_cfg.amplitude == 6'h18
      && divide_cfg.int_ratio == 7'h38 && pump_cfg.mon_sel == 3'h0; endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad defaults");
   // Main scenarios reached
   c_int_mode: cover property (!divide_cfg.frac_mode);
   c_cal: cover property (cal_start);
   c_band: cover property (osc_cfg.band_from_spi);
endmodule // synth_regs_monitor

bind synth_pll_control_registers synth_regs_monitor u_mon (.clk(clk), .rst_b(rst_b),
   .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le), .lock_detect(lock_detect),
   .cal_done(cal_done), .divide_cfg(divide_cfg), .pump_cfg(pump_cfg), .osc_cfg(osc_cfg),
   .band_active(band_active), .cal_start(cal_start), .cal_busy(cal_busy),
   .monitor_output_pin(monitor_output_pin));

/* File: verification/serial_host_model.sv */
// Serial host model that shifts programming words into the bank
`timescale 1ns/1ps
module serial_host_model (
   // Three-wire port toward the device
   output logic ser_clk,
   output logic ser_data,
   output logic ser_le
);
   // Idle port; one pulse inside reset so the link side sees an edge
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_le = 1'b0;
      #50 ser_clk = 1'b1;
      #6 ser_clk = 1'b0;
   end
   // One frame, MSB first; fewer than 24 bits makes a short frame, more than 24 lead with zeros
   task automatic send(input logic [23:0] word, input int nbits);
      for (int i = nbits - 1; i >= 0; i--) begin
         ser_data = (i < 24) ? word[i] : 1'b0;
         #6 ser_clk = 1'b1;
         #6 ser_clk = 1'b0;
      end
      // Latch edge; data no longer valid, so it shows the inverse
      ser_le = 1'b1;
      ser_data = ~ser_data;
      #6 ser_clk = 1'b1;
      #6 ser_clk = 1'b0;
      ser_le = 1'b0;
   endtask
endmodule // serial_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the synthesizer control register bank
`timescale 1ns/1ps
module tb_top;
   // ==========================================
   // Stimulus, observed outputs, counters
   logic clk;
   logic rst_b;
   logic lock_detect;
   logic cal_done;
   wire logic ser_clk;
   wire logic ser_data;
   wire logic ser_le;
   synth_regs_pkg::divide_cfg_t divide_cfg;
   synth_regs_pkg::pump_cfg_t pump_cfg;
   synth_regs_pkg::osc_cfg_t osc_cfg;
   logic [5:0] band_active;
   logic cal_start;
   logic cal_busy;
   logic monitor_output_pin;
   logic [1:0] m;
   int nb[3] = '{23, 25, 24};
   // Expected {ratio, mode, cal pulses}; a long frame keeps its last 24 bits
   logic [10:0] ex[3] = '{11'h18C, 11'h7B5, 11'h7B5};
   int fail_count = 0;
   int num_checks = 0;
   int cal_count = 0;
   int cycles = 0;
   // ==========================================
   // Instances
   serial_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
   synth_pll_control_registers dut (.clk(clk), .rst_b(rst_b), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_le(ser_le), .lock_detect(lock_detect), .cal_done(cal_done),
      .divide_cfg(divide_cfg), .pump_cfg(pump_cfg), .osc_cfg(osc_cfg),
      .band_active(band_active), .cal_start(cal_start), .cal_busy(cal_busy),
      .monitor_output_pin(monitor_output_pin));
   // 50 MHz system clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Calibration pulses and hang guard
   always @(posedge clk) begin
      cycles++;
      if (cal_start === 1'b1) cal_count++;
      if (cycles == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   // ==========================================
   // Tasks
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One frame, then room for update and calibration pulse
   task automatic wr(input logic [23:0] w, input int n = 24);
      host.send(w, n);
      repeat (8) @(posedge clk);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      lock_detect = 1'b0;
      cal_done = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      chk(divide_cfg, {1'b1, 7'd56, 11'd1536, 11'd768, 17'd1});
      chk(osc_cfg.amplitude, 6'd24);
      chk({pump_cfg.pump_mult, pump_cfg.mon_sel, monitor_output_pin}, 7'h10);
      lock_detect <= 1'b1;
      // Setup registers first, highest select down
      wr(24'h147F56);
      chk(osc_cfg.band_sel, 6'h2A);
      chk({osc_cfg.band_from_spi, osc_cfg.amplitude, band_active}, 13'h17EA);
      chk({osc_cfg.pump_en, osc_cfg.reg33_en, osc_cfg.osc_reg_en, osc_cfg.vco_en}, 4'hA);
      wr(24'h00001D);
      chk({osc_cfg.lo_port_out, osc_cfg.lo_div2, osc_cfg.demod_bias_en}, 3'h6);
      wr(24'h08000B);
      chk(divide_cfg.dither, 17'h10001);
      chk(cal_count, 0);
      // Frequency registers last, numerator below modulus
      wr(24'h00091A);
      chk({divide_cfg.numerator, cal_busy}, {11'h123, 1'b1});
      wr(24'h003FF9);
      chk(divide_cfg.modulus, 11'h7FF);
      wr(24'h0007D8);
      chk(divide_cfg, {1'b0, 7'h7B, 11'h1, 11'h0, 17'h10001});
      wr(24'h0000C0);
      chk(divide_cfg, {1'b1, 7'h18, 11'h7FF, 11'h123, 17'h10001});
      chk(cal_count, 4);
      // Short frame and unused select change nothing; long frame lands
      for (int k = 0; k < 3; k++) begin
         wr((k == 2) ? 24'h0007DF : 24'h0007D8, nb[k]);
         chk({divide_cfg.int_ratio, divide_cfg.frac_mode, 3'(cal_count)}, ex[k]);
      end
      // Every multiplier and scale code, monitor codes 0 to 3; busy still high
      for (int i = 3; i >= 0; i--) begin
         m = 2'(i);
         wr({1'b0, m, m, m[1], m[0], 5'h15, m, 7'h00, 3'h4});
         chk(pump_cfg, {m[1], 3'(m) + 3'h1, 5'h15, m[0], m, 1'b0, m});
         chk(monitor_output_pin, m != 2'h3);
      end
      // Calibration finished clears busy
      cal_done <= 1'b1;
      repeat (6) @(posedge clk);
      chk(cal_busy, 1'b0);
      // Field source off: oscillator keeps the last calibrated band
      cal_done <= 1'b0;
      wr(24'h147CAE);
      chk({osc_cfg.band_sel, band_active}, 12'h56A);
      give_verdict();
   end
endmodule // tb_top
